// file: tb/ibl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ibl_checker
   import ibl_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        por_rst,
   input wire logic        scl_oe,
   input wire logic        sda_oe,
   input wire logic        cpu_reset,
   input wire logic        ram_we,
   input wire logic [15:0] ram_addr,
   input wire logic        gp_dat_wr,
   input wire logic [7:0]  serial_bus_control_register
);
   logic por_q;
   logic busy;
   logic [11:0] busy_cnt_q;
   assign busy = serial_bus_control_register[CTL_BUSY];
   // Reset cause as seen at the last reset cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         por_q <= por_rst;
      end
   end
   // Cycles spent busy on the current firmware request
   always_ff @(posedge mclk) begin
      if (rst || !busy) begin
         busy_cnt_q <= 12'h000;
      end else if (busy_cnt_q != 12'hfff) begin
         busy_cnt_q <= busy_cnt_q + 12'h001;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   cpu_hold_a: assert property (ram_we |-> cpu_reset) else $error("ram write with cpu running");
   boot_hold_a: assert property ($fell(rst) && por_q |-> cpu_reset [*8]) else $error("cpu released early");
   boot_start_a: assert property ($fell(rst) && por_q |-> ##[1:120] sda_oe) else $error("no boot start");
   warm_release_a: assert property ($fell(rst) && !por_q |=> !cpu_reset) else $error("cpu held");
   warm_idle_a: assert property (!por_q |-> !ram_we) else $error("load after warm reset");
   ram_window_a: assert property (ram_we |-> ram_addr <= CODE_END || (ram_addr >= SCR_LO && ram_addr <= SCR_HI))
      else $error("write outside ram");
   ram_pulse_a: assert property (ram_we |=> !ram_we) else $error("write pulse too long");
   port_handover_a: assert property ($fell(cpu_reset) |-> !scl_oe && !sda_oe) else $error("bus busy");
   boot_block_a: assert property (cpu_reset |=> $stable(serial_bus_control_register))
      else $error("request taken in boot");
   master_only_a: assert property (!cpu_reset && !busy && !scl_oe |-> !sda_oe) else $error("idle sda");
   gp_take_a: assert property (!cpu_reset && !busy && gp_dat_wr |-> ##[1:3] busy) else $error("no busy");
   gp_span_a: assert property (busy |-> busy_cnt_q < 12'h7d0) else $error("busy stuck");
   gp_short_a: assert property ($fell(busy) |-> busy_cnt_q >= 12'h064) else $error("busy too short");
   gp_done_a: assert property ($fell(busy) |-> serial_bus_control_register[CTL_DONE]) else $error("no done");
   boot_load_c: cover property (ram_we && ram_addr >= SCR_LO);
   gp_ack_c: cover property ($fell(busy) && serial_bus_control_register[CTL_ACK]);
   boot_end_c: cover property ($fell(cpu_reset) && por_q);
endmodule // ibl_checker
bind ibl_top ibl_checker u_chk (.mclk(mclk), .rst(rst), .por_rst(por_rst), .scl_oe(scl_oe), .sda_oe(sda_oe),
   .cpu_reset(cpu_reset), .ram_we(ram_we), .ram_addr(ram_addr), .gp_dat_wr(gp_dat_wr),
   .serial_bus_control_register(serial_bus_control_register));
`default_nettype wire

// file: tb/ibl_eeprom_model.sv
`timescale 1ns/1ps
`default_nettype none
module ibl_eeprom_model (
   input  wire logic       mclk,
   input  wire logic       strap_large,
   input  wire logic [7:0] image [32],
   input  wire logic       scl,
   input  wire logic       sda,
   output var  logic       sda_oe
);
   logic       scl_q = 1'b1;
   logic       sda_q = 1'b1;
   logic       active_q = 1'b0;
   logic       ctl_q = 1'b0;
   logic       rd_q = 1'b0;
   logic [3:0] bitn_q = 4'h0;
   logic [7:0] sh_q = 8'h00;
   logic [4:0] ptr_q = 5'h00;
   initial sda_oe = 1'b0;
   // Open drain: released line floats to the pull-up
   always @(posedge mclk) begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda) begin
         active_q <= 1'b1;
         ctl_q <= 1'b1;
         rd_q <= 1'b0;
         bitn_q <= 4'h0;
         sda_oe <= 1'b0;
      end else if (scl && scl_q && !sda_q && sda) begin
         active_q <= 1'b0;
         sda_oe <= 1'b0;
      end else if (active_q && scl && !scl_q) begin
         sh_q <= {sh_q[6:0], sda};
         bitn_q <= (bitn_q == 4'h8) ? 4'h0 : bitn_q + 4'h1;
         if (bitn_q == 4'h8 && rd_q && sda) begin
            active_q <= 1'b0;
         end
      end else if (active_q && !scl && scl_q) begin
         if (bitn_q == 4'h8) begin
            if (ctl_q) begin
               if (sh_q[7:1] == {6'h28, strap_large}) begin
                  sda_oe <= 1'b1;
                  rd_q <= sh_q[0];
                  ctl_q <= 1'b0;
               end else begin
                  active_q <= 1'b0;
               end
            end else if (!rd_q) begin
               ptr_q <= sh_q[4:0];
               sda_oe <= 1'b1;
            end else begin
               sda_oe <= 1'b0;
               ptr_q <= ptr_q + 5'h01;
            end
         end else if (rd_q) begin
            sda_oe <= !image[ptr_q][3'h7 - bitn_q[2:0]];
         end else begin
            sda_oe <= 1'b0;
         end
      end
   end
endmodule // ibl_eeprom_model
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ibl_pkg::*;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        por_rst = 1'b1;
   logic        ee_large = 1'b0;
   logic        strap_large = 1'b0;
   logic        gp_ctl_wr = 1'b0;
   logic [7:0]  gp_ctl_wdata = 8'h00;
   logic        gp_dat_wr = 1'b0;
   logic [7:0]  gp_dat_wdata = 8'h00;
   logic        gp_dat_rd = 1'b0;
   logic        scl_oe;
   logic        sda_oe;
   logic        scl_o;
   logic        sda_o;
   logic        ee_sda_oe;
   logic        cpu_reset;
   logic        ram_we;
   logic [15:0] ram_addr;
   logic [7:0]  ram_wdata;
   logic [47:0] ids;
   logic [7:0]  boot_config;
   logic [7:0]  ctl;
   logic [7:0]  dat;
   logic [7:0]  img [32];
   logic [23:0] ram_log [$];
   logic [23:0] exp_log [$];
   logic [31:0] lfsr_state = 32'h1a05_ebb5;
   logic [7:0]  off;
   int          num_errors = 0;
   int          comparisons = 0;
   int          cycles = 0;
   wire logic   scl_w = !scl_oe;
   wire logic   sda_w = !sda_oe && !ee_sda_oe;
   always #50 mclk = ~mclk;
   ibl_top u_dut (.mclk(mclk), .rst(rst), .por_rst(por_rst), .ee_large(ee_large), .scl_i(scl_w), .scl_o(scl_o),
      .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .cpu_reset(cpu_reset), .ram_we(ram_we),
      .ram_addr(ram_addr), .ram_wdata(ram_wdata), .vendor_product_device_ids(ids), .boot_config(boot_config),
      .gp_ctl_wr(gp_ctl_wr), .gp_ctl_wdata(gp_ctl_wdata), .gp_dat_wr(gp_dat_wr), .gp_dat_wdata(gp_dat_wdata),
      .gp_dat_rd(gp_dat_rd), .serial_bus_control_register(ctl), .serial_bus_data_register(dat));
   ibl_eeprom_model u_ee (.mclk(mclk), .strap_large(strap_large), .image(img), .scl(scl_w), .sda(sda_w),
      .sda_oe(ee_sda_oe));
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (ram_we === 1'b1) ram_log.push_back({ram_addr, ram_wdata});
      if (cycles == 95000) begin
         num_errors++;
         $display("MISMATCH %0t timeout", $time);
         conclude();
      end
   end
   function automatic logic [7:0] rnd();
      lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
      return lfsr_state[7:0];
   endfunction
   // Walk the image records and keep only bytes that fall in the ram windows
   function automatic void build_expect();
      int p;
      int n;
      logic [15:0] a;
      exp_log.delete();
      p = 8;
      while (img[0] == TAG_IDS_PROG && img[p][7] == 1'b0) begin
         n = {img[p][6:0], img[p + 1]};
         a = {img[p + 2], img[p + 3]};
         p += 4;
         repeat (n) begin
            if (a <= CODE_END || (a >= SCR_LO && a <= SCR_HI)) exp_log.push_back({a, img[p]});
            a++;
            p++;
         end
      end
   endfunction
   task automatic chk(input logic ok, input string what);
      comparisons++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("MISMATCH %0t %s", $time, what);
      end
   endtask
   task automatic do_reset(input logic por, input logic dut_large, input logic ee_strap);
      @(posedge mclk);
      rst <= 1'b1;
      por_rst <= por;
      ee_large <= dut_large;
      strap_large <= ee_strap;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      ram_log.delete();
   endtask
   task automatic wait_boot;
      int i;
      i = 0;
      while (cpu_reset !== 1'b0 && i < 40000) begin
         @(posedge mclk);
         #1;
         i++;
      end
      chk(cpu_reset === 1'b0, "boot did not finish");
   endtask
   task automatic check_boot;
      build_expect();
      chk(ids === {img[1], img[2], img[3], img[4], img[5], img[6]}, "ids");
      chk(boot_config === img[7], "config byte");
      chk(ram_log.size() == exp_log.size(), "ram write count");
      foreach (exp_log[i]) chk(ram_log[i] === exp_log[i], "ram write");
   endtask
   task automatic gp_wait;
      int i;
      i = 0;
      repeat (3) @(posedge mclk);
      #1;
      while (ctl[CTL_BUSY] !== 1'b0 && i < 3000) begin
         @(posedge mclk);
         #1;
         i++;
      end
      chk(ctl[CTL_DONE] === 1'b1, "no done");
   endtask
   task automatic gp_ctl(input logic [7:0] v);
      @(posedge mclk);
      gp_ctl_wr <= 1'b1;
      gp_ctl_wdata <= v;
      @(posedge mclk);
      gp_ctl_wr <= 1'b0;
      if (v[CTL_STOP]) gp_wait();
   endtask
   task automatic gp_byte(input logic rd, input logic [7:0] v);
      @(posedge mclk);
      gp_dat_rd <= rd;
      gp_dat_wr <= !rd;
      gp_dat_wdata <= v;
      @(posedge mclk);
      gp_dat_rd <= 1'b0;
      gp_dat_wr <= 1'b0;
      gp_wait();
   endtask
   task automatic conclude;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      for (int i = 0; i < 32; i++) img[i] = rnd();
      img[0] = TAG_IDS_PROG;
      img[8:11] = '{8'h00, 8'h02, 8'h3f, 8'hff};
      img[14:17] = '{8'h00, 8'h02, 8'he1, 8'hff};
      img[20] = 8'h80;
      do_reset(1'b1, 1'b0, 1'b0);
      repeat (10) @(posedge mclk);
      #1;
      chk(cpu_reset === 1'b1, "cpu not held");
      gp_ctl(8'ha0);
      @(posedge mclk) gp_dat_rd <= 1'b1;
      @(posedge mclk) gp_dat_rd <= 1'b0;
      wait_boot();
      check_boot();
      chk(ctl[7:5] === 3'h0, "request taken during boot");
      gp_ctl(8'h80);
      gp_byte(1'b0, 8'hb0);
      chk(ctl[CTL_ACK] === 1'b0, "absent device acked");
      gp_ctl(8'h40);
      repeat (2) begin
         off = rnd() % 8'd22;
         gp_ctl(8'h80);
         gp_byte(1'b0, EE_CTL_SMALL);
         chk(ctl[CTL_ACK] === 1'b1, "memory not acked");
         gp_ctl(8'h00);
         gp_byte(1'b0, off);
         gp_ctl(8'h80);
         gp_byte(1'b0, EE_CTL_SMALL | EE_RD_BIT);
         gp_ctl(8'h20);
         gp_byte(1'b1, 8'h00);
         chk(dat === img[off[4:0]], "read data");
         gp_ctl(8'h40);
      end
      do_reset(1'b0, 1'b0, 1'b0);
      repeat (3) @(posedge mclk);
      #1;
      chk(cpu_reset === 1'b0, "cpu held after warm reset");
      repeat (300) @(posedge mclk);
      #1;
      chk(ram_log.size() == 0 && scl_oe === 1'b0, "boot after warm reset");
      img[0] = TAG_IDS_ONLY;
      do_reset(1'b1, 1'b1, 1'b1);
      wait_boot();
      check_boot();
      do_reset(1'b1, 1'b0, 1'b1);
      wait_boot();
      chk(ram_log.size() == 0 && scl_oe === 1'b0 && sda_oe === 1'b0, "load despite nack");
      chk(scl_o === 1'b0 && sda_o === 1'b0, "pin drive level");
      conclude();
   end
endmodule // tb
`default_nettype wire

// file: verilog/ibl_byte_engine.sv
`timescale 1ns/1ps
`default_nettype none
module ibl_byte_engine
   import ibl_pkg::*;
(
   input  wire logic     mclk,
   input  wire logic     rst,
   input  wire ibl_cmd_t cmd,
   input  wire logic     scl_in,
   input  wire logic     sda_in,
   output var  ibl_rsp_t rsp,
   output var  logic     scl_oe,
   output var  logic     sda_oe
);

   typedef enum logic [1:0] {E_IDLE, E_START, E_BIT, E_STOP} ibl_eng_t;

   ibl_eng_t   st_q;
   logic [7:0] qcnt_q;
   logic [1:0] ph_q;
   logic [3:0] bit_q;
   logic [8:0] sh_q;
   logic       tick;

   // Stretch: hold the high phase while a slave keeps the clock low
   assign tick = (qcnt_q == 8'h00) && !(st_q == E_BIT && ph_q == 2'd1 && !scl_in);

   always_ff @(posedge mclk) begin
      if (rst) begin
         st_q   <= E_IDLE;
         qcnt_q <= 8'h00;
         ph_q   <= 2'd0;
         bit_q  <= 4'h0;
         sh_q   <= 9'h1FF;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         rsp    <= '0;
      end else if (st_q == E_IDLE) begin
         rsp.done <= 1'b0;
         ph_q     <= 2'd0;
         bit_q    <= 4'h0;
         qcnt_q   <= QUARTER_CYC - 8'h01;
         if (cmd.valid) begin
            unique case (cmd.op)
               OP_START: begin
                  st_q   <= E_START;
                  sda_oe <= 1'b0;
               end
               OP_STOP: begin
                  st_q   <= E_STOP;
                  sda_oe <= 1'b1;
               end
               OP_WRITE: begin
                  st_q   <= E_BIT;
                  sh_q   <= {cmd.data, 1'b1};
                  sda_oe <= ~cmd.data[7];
               end
               OP_READ: begin
                  st_q   <= E_BIT;
                  sh_q   <= {8'hFF, ~cmd.ack};
                  sda_oe <= 1'b0;
               end
            endcase
         end
      end else if (!tick) begin
         if (qcnt_q != 8'h00) qcnt_q <= qcnt_q - 8'h01;
      end else begin
         qcnt_q <= QUARTER_CYC - 8'h01;
         ph_q   <= ph_q + 2'd1;
         unique case (st_q)
            E_START: begin
               if (ph_q == 2'd0) scl_oe <= 1'b0;
               if (ph_q == 2'd1) sda_oe <= 1'b1;
               if (ph_q == 2'd2) scl_oe <= 1'b1;
               if (ph_q == 2'd3) begin
                  st_q     <= E_IDLE;
                  rsp.done <= 1'b1;
               end
            end
            E_BIT: begin
               if (ph_q == 2'd0) scl_oe <= 1'b0;
               if (ph_q == 2'd1) sh_q <= {sh_q[7:0], sda_in};
               if (ph_q == 2'd2) scl_oe <= 1'b1;
               if (ph_q == 2'd3) begin
                  if (bit_q == 4'h8) begin
                     st_q       <= E_IDLE;
                     rsp.done   <= 1'b1;
                     rsp.rdata  <= sh_q[8:1];
                     rsp.ack_rx <= ~sh_q[0];
                  end else begin
                     bit_q  <= bit_q + 4'h1;
                     sda_oe <= ~sh_q[8];
                  end
               end
            end
            E_STOP: begin
               if (ph_q == 2'd0) scl_oe <= 1'b0;
               if (ph_q == 2'd1) sda_oe <= 1'b0;
               if (ph_q == 2'd3) begin
                  st_q     <= E_IDLE;
                  rsp.done <= 1'b1;
               end
            end
            default: st_q <= E_IDLE;
         endcase
      end
   end

endmodule // ibl_byte_engine
`default_nettype wire

// file: verilog/ibl_pkg.sv
package ibl_pkg;

   // Serial clock timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int SCL_PERIOD_NS = 10000;
   localparam int QUARTER_NS    = SCL_PERIOD_NS / 4;
   localparam int QUARTER_INT   = (QUARTER_NS / CLK_PERIOD_NS) < 1 ? 1 : (QUARTER_NS / CLK_PERIOD_NS);
   localparam logic [7:0] QUARTER_CYC = 8'(QUARTER_INT);

   // Boot memory control bytes
   localparam logic [7:0] EE_CTL_SMALL = 8'hA0;
   localparam logic [7:0] EE_CTL_LARGE = 8'hA2;
   localparam logic [7:0] EE_RD_BIT    = 8'h01;
   localparam logic [7:0] EE_OFFSET    = 8'h00;

   // Boot image layout
   localparam logic [7:0] TAG_IDS_ONLY = 8'h01;
   localparam logic [7:0] TAG_IDS_PROG = 8'h02;
   localparam logic [3:0] ID_BYTES     = 4'h7;
   localparam logic [3:0] HDR_BYTES    = 4'h4;
   localparam int         HDR_END_BIT  = 7;

   // Internal RAM windows
   localparam logic [15:0] CODE_END  = 16'h3FFF;
   localparam logic [15:0] SCR_LO    = 16'hE000;
   localparam logic [15:0] SCR_HI    = 16'hE1FF;
   localparam logic [14:0] LOAD_MAX  = 15'h4000;

   // Control register fields
   localparam int CTL_START  = 7;
   localparam int CTL_STOP   = 6;
   localparam int CTL_LASTRD = 5;
   localparam int CTL_ACK    = 2;
   localparam int CTL_BUSY   = 1;
   localparam int CTL_DONE   = 0;

   typedef enum logic [1:0] {OP_START, OP_WRITE, OP_READ, OP_STOP} ibl_op_t;

   typedef struct packed {
      logic       valid;
      ibl_op_t    op;
      logic [7:0] data;
      logic       ack;
   } ibl_cmd_t;

   typedef struct packed {
      logic       done;
      logic       ack_rx;
      logic [7:0] rdata;
   } ibl_rsp_t;

endpackage

// file: verilog/ibl_top.sv
// How it works
// - One serial port, boot loader and firmware controller
// - Master only; never answers as a slave
// - Power-on boot reads ids then program bytes
// - Loaded bytes land only in code/scratch RAM
// - Processor held in reset during boot load
// - Boot load starts only after power-on reset
// - Memory address chosen by size strap
// - Firmware drives bus via control/data registers
`timescale 1ns/1ps
`default_nettype none
module ibl_top
   import ibl_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        por_rst,
   input  wire logic        ee_large,
   input  wire logic        scl_i,
   output var  logic        scl_o,
   output var  logic        scl_oe,
   input  wire logic        sda_i,
   output var  logic        sda_o,
   output var  logic        sda_oe,
   output var  logic        cpu_reset,
   output var  logic        ram_we,
   output var  logic [15:0] ram_addr,
   output var  logic [7:0]  ram_wdata,
   output var  logic [47:0] vendor_product_device_ids,
   output var  logic [7:0]  boot_config,
   input  wire logic        gp_ctl_wr,
   input  wire logic [7:0]  gp_ctl_wdata,
   input  wire logic        gp_dat_wr,
   input  wire logic [7:0]  gp_dat_wdata,
   input  wire logic        gp_dat_rd,
   output var  logic [7:0]  serial_bus_control_register,
   output var  logic [7:0]  serial_bus_data_register
);

   typedef enum logic [3:0] {B_IDLE, B_ST1, B_CTLW, B_OFFH, B_OFFL, B_ST2, B_CTLR,
                             B_RD, B_LAST, B_STOP, B_DONE} ibl_boot_t;
   typedef enum logic [1:0] {P_TAG, P_ID, P_HDR, P_DATA} ibl_phase_t;
   typedef enum logic [1:0] {G_IDLE, G_START, G_XFER, G_STOP} ibl_gp_t;

   logic [2:0]  sync1_q, sync2_q;
   ibl_boot_t   bst_q;
   ibl_phase_t  phase_q;
   ibl_gp_t     gst_q;
   logic        iss_q, prog_q, end_q;
   logic [3:0]  cnt_q;
   logic [15:0] len_q, addr_q;
   logic [14:0] loaded_q;
   ibl_cmd_t    boot_cmd_q, gp_cmd_q, eng_cmd, boot_next;
   ibl_rsp_t    rsp;
   ibl_op_t     gp_op_q;
   logic [7:0]  gp_data_q;
   logic        gp_ack_q;
   logic        boot_own, in_range, eng_scl_oe, eng_sda_oe;

   // Pin and strap synchronisers
   always_ff @(posedge mclk) begin
      if (rst) begin
         sync1_q <= 3'b111;
         sync2_q <= 3'b111;
      end else begin
         sync1_q <= {ee_large, scl_i, sda_i};
         sync2_q <= sync1_q;
      end
   end

   // Port ownership and the shared engine
   assign boot_own = (bst_q != B_DONE);
   assign eng_cmd  = boot_own ? boot_cmd_q : gp_cmd_q;

   ibl_byte_engine u_engine (
      .mclk   (mclk),
      .rst    (rst),
      .cmd    (eng_cmd),
      .scl_in (sync2_q[1]),
      .sda_in (sync2_q[0]),
      .rsp    (rsp),
      .scl_oe (eng_scl_oe),
      .sda_oe (eng_sda_oe)
   );

   // Open-drain drive only: no slave address decode exists
   assign scl_o  = 1'b0;
   assign sda_o  = 1'b0;
   assign scl_oe = eng_scl_oe;
   assign sda_oe = eng_sda_oe;

   // Command for the current boot step
   always_comb begin
      boot_next       = '0;
      boot_next.valid = 1'b1;
      boot_next.op    = OP_WRITE;
      boot_next.ack   = 1'b1;
      unique case (bst_q)
         B_ST1, B_ST2: boot_next.op = OP_START;
         B_CTLW:       boot_next.data = sync2_q[2] ? EE_CTL_LARGE : EE_CTL_SMALL;
         B_CTLR:       boot_next.data = (sync2_q[2] ? EE_CTL_LARGE : EE_CTL_SMALL) | EE_RD_BIT;
         B_OFFH, B_OFFL: boot_next.data = EE_OFFSET;
         B_RD:         boot_next.op = OP_READ;
         B_LAST: begin
            boot_next.op  = OP_READ;
            boot_next.ack = 1'b0;
         end
         B_STOP:       boot_next.op = OP_STOP;
         default:      boot_next.valid = 1'b0;
      endcase
   end

   assign in_range = (addr_q <= CODE_END) || (addr_q >= SCR_LO && addr_q <= SCR_HI);

   // Boot sequencer
   always_ff @(posedge mclk) begin
      if (rst) begin
         bst_q      <= por_rst ? B_ST1 : B_DONE;
         boot_cmd_q <= '0;
         iss_q      <= 1'b0;
         phase_q    <= P_TAG;
         cnt_q      <= 4'h0;
         prog_q     <= 1'b0;
         end_q      <= 1'b0;
         len_q      <= 16'h0000;
         addr_q     <= 16'h0000;
         loaded_q   <= 15'h0000;
         ram_we     <= 1'b0;
         ram_addr   <= 16'h0000;
         ram_wdata  <= 8'h00;
         vendor_product_device_ids <= 48'h0000_0000_0000;
         boot_config <= 8'h00;
      end else begin
         boot_cmd_q.valid <= 1'b0;
         ram_we           <= 1'b0;
         if (boot_own && bst_q != B_IDLE && !iss_q) begin
            boot_cmd_q <= boot_next;
            iss_q      <= 1'b1;
         end else if (boot_own && rsp.done) begin
            iss_q <= 1'b0;
            unique case (bst_q)
               B_ST1:  bst_q <= B_CTLW;
               B_CTLW: bst_q <= !rsp.ack_rx ? B_STOP : (sync2_q[2] ? B_OFFH : B_OFFL);
               B_OFFH: bst_q <= rsp.ack_rx ? B_OFFL : B_STOP;
               B_OFFL: bst_q <= rsp.ack_rx ? B_ST2 : B_STOP;
               B_ST2:  bst_q <= B_CTLR;
               B_CTLR: bst_q <= rsp.ack_rx ? B_RD : B_STOP;
               B_RD: begin
                  unique case (phase_q)
                     P_TAG: begin
                        prog_q  <= (rsp.rdata == TAG_IDS_PROG);
                        phase_q <= P_ID;
                        if (rsp.rdata != TAG_IDS_PROG && rsp.rdata != TAG_IDS_ONLY) bst_q <= B_LAST;
                     end
                     P_ID: begin
                        if (cnt_q == ID_BYTES - 4'h1) begin
                           boot_config <= rsp.rdata;
                           cnt_q       <= 4'h0;
                           phase_q     <= P_HDR;
                           if (!prog_q) bst_q <= B_LAST;
                        end else begin
                           vendor_product_device_ids <= {vendor_product_device_ids[39:0], rsp.rdata};
                           cnt_q <= cnt_q + 4'h1;
                        end
                     end
                     P_HDR: begin
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == 4'h0) begin
                           len_q[15:8] <= rsp.rdata;
                           end_q       <= rsp.rdata[HDR_END_BIT];
                        end
                        if (cnt_q == 4'h1) len_q[7:0] <= rsp.rdata;
                        if (cnt_q == 4'h2) addr_q[15:8] <= rsp.rdata;
                        if (cnt_q == 4'h3) addr_q[7:0] <= rsp.rdata;
                        if (cnt_q == HDR_BYTES - 4'h1) begin
                           cnt_q   <= 4'h0;
                           phase_q <= P_DATA;
                           if (end_q || len_q == 16'h0000) bst_q <= B_LAST;
                        end
                     end
                     P_DATA: begin
                        if (in_range && loaded_q < LOAD_MAX) begin
                           ram_we    <= 1'b1;
                           ram_addr  <= addr_q;
                           ram_wdata <= rsp.rdata;
                           loaded_q  <= loaded_q + 15'h0001;
                        end
                        addr_q <= addr_q + 16'h0001;
                        len_q  <= len_q - 16'h0001;
                        if (len_q == 16'h0001) phase_q <= P_HDR;
                     end
                  endcase
               end
               B_LAST: bst_q <= B_STOP;
               B_STOP: bst_q <= B_DONE;
               default: bst_q <= B_DONE;
            endcase
         end
      end
   end

   // Processor reset follows the boot sequence
   always_ff @(posedge mclk) begin
      if (rst) cpu_reset <= 1'b1;
      else     cpu_reset <= boot_own;
   end

   // Firmware controller: control and data registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         gst_q     <= G_IDLE;
         gp_cmd_q  <= '0;
         gp_op_q   <= OP_WRITE;
         gp_data_q <= 8'h00;
         gp_ack_q  <= 1'b1;
         serial_bus_control_register <= 8'h00;
         serial_bus_data_register    <= 8'h00;
      end else begin
         gp_cmd_q.valid <= 1'b0;
         serial_bus_control_register[CTL_BUSY] <= (gst_q != G_IDLE);
         unique case (gst_q)
            G_IDLE: begin
               if (!boot_own && !cpu_reset) begin
                  if (gp_ctl_wr) begin
                     serial_bus_control_register[7:5] <= gp_ctl_wdata[7:5];
                     if (gp_ctl_wdata[CTL_STOP]) begin
                        gp_cmd_q <= '{valid: 1'b1, op: OP_STOP, data: 8'h00, ack: 1'b0};
                        gst_q    <= G_STOP;
                        serial_bus_control_register[CTL_DONE] <= 1'b0;
                     end
                  end else if (gp_dat_wr || gp_dat_rd) begin
                     gp_op_q   <= gp_dat_wr ? OP_WRITE : OP_READ;
                     gp_data_q <= gp_dat_wdata;
                     gp_ack_q  <= ~serial_bus_control_register[CTL_LASTRD];
                     serial_bus_control_register[CTL_DONE] <= 1'b0;
                     if (gp_dat_wr && serial_bus_control_register[CTL_START]) begin
                        gp_cmd_q <= '{valid: 1'b1, op: OP_START, data: 8'h00, ack: 1'b0};
                        gst_q    <= G_START;
                        serial_bus_control_register[CTL_START] <= 1'b0;
                     end else begin
                        gp_cmd_q <= '{valid: 1'b1, op: gp_dat_wr ? OP_WRITE : OP_READ, data: gp_dat_wdata,
                                      ack: ~serial_bus_control_register[CTL_LASTRD]};
                        gst_q    <= G_XFER;
                     end
                  end
               end
            end
            G_START: begin
               if (rsp.done) begin
                  gp_cmd_q <= '{valid: 1'b1, op: gp_op_q, data: gp_data_q, ack: gp_ack_q};
                  gst_q    <= G_XFER;
               end
            end
            G_XFER: begin
               if (rsp.done) begin
                  gst_q <= G_IDLE;
                  serial_bus_control_register[CTL_DONE] <= 1'b1;
                  serial_bus_control_register[CTL_ACK]  <= rsp.ack_rx;
                  if (gp_op_q == OP_READ) serial_bus_data_register <= rsp.rdata;
               end
            end
            G_STOP: begin
               if (rsp.done) begin
                  gst_q <= G_IDLE;
                  serial_bus_control_register[CTL_STOP] <= 1'b0;
                  serial_bus_control_register[CTL_DONE] <= 1'b1;
               end
            end
         endcase
      end
   end

endmodule // ibl_top
`default_nettype wire
